// ### include/sspi_params.svh
`ifndef SSPI_PARAMS_SVH
`define SSPI_PARAMS_SVH

// register byte offsets on the apb bus
`define SSPI_OFF_PD_CTRL  8'h00
`define SSPI_OFF_PD_DIR   8'h04
`define SSPI_OFF_PD_DATA  8'h08
`define SSPI_OFF_CFG      8'h0C
`define SSPI_OFF_TX       8'h10
`define SSPI_OFF_RX       8'h14
`define SSPI_OFF_STAT     8'h18

// shared pin positions on port d
`define SSPI_NPINS        6
`define SSPI_PIN_SC0      0
`define SSPI_PIN_SC1      1
`define SSPI_PIN_SC2      2
`define SSPI_PIN_SCK      3
`define SSPI_PIN_SRD      4
`define SSPI_PIN_STD      5

// status register bit positions
`define SSPI_ST_TX_FULL   0
`define SSPI_ST_RX_FULL   1
`define SSPI_ST_RX_OVR    2
`define SSPI_ST_TX_BUSY   3
`define SSPI_ST_RX_BUSY   4
`define SSPI_ST_FLAG0     5
`define SSPI_ST_FLAG1     6

// widths and reset values
`define SSPI_CFG_W        16
`define SSPI_CFG_RST      16'h0400
`define SSPI_PINS_RST     6'h00
`define SSPI_WORD_W       8

`endif

// ### include/sspi_pkg.sv
package sspi_pkg;

  // serial configuration register, lsb first from the bottom field
  typedef struct packed {
    logic [7:0] div;
    logic       enable;
    logic       flag1;
    logic       flag0;
    logic       sc1_out;
    logic       sc0_out;
    logic       fs_out;
    logic       sck_out;
    logic       async_mode;
  } sspi_cfg_t;

  // function-side drive request for all six shared pins
  typedef struct packed {
    logic [5:0] oe;
    logic [5:0] out;
  } sspi_pinfn_t;

  typedef enum {st_idle, st_shift} sspi_shift_t;

endpackage

// ### rtl/sspi_sync.sv
`timescale 1ns/10ps
module sspi_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_q;
  logic [W-1:0] q_d;

  // two stages; en low freezes both so an ignored input stays put
  always_comb begin
    meta_d = en ? d : meta_q;
    q_d    = en ? meta_q : q_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q_q    <= '0;
    end else begin
      meta_q <= meta_d;
      q_q    <= q_d;
    end
  end

  assign q = q_q;

endmodule

// ### rtl/sspi_pin_cell.sv
`timescale 1ns/10ps
`include "sspi_params.svh"
module sspi_pin_cell (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic stop,
  input  wire logic func_sel,
  input  wire logic gpio_dir,
  input  wire logic gpio_out,
  input  wire logic fn_oe,
  input  wire logic fn_out,
  output logic      pin_out,
  output logic      pin_oe
);

  logic out_q;
  logic out_d;
  logic oe_q;
  logic oe_d;

  // pick gpio or serial drive; stop floats any output but keeps the level
  always_comb begin
    out_d = out_q;
    oe_d  = oe_q;
    if (ce) begin
      if (stop) begin
        oe_d = 1'b0;
      end else if (func_sel) begin
        out_d = fn_out;
        oe_d  = fn_oe;
      end else begin
        out_d = gpio_out;
        oe_d  = gpio_dir;
      end
    end
  end

  // reset leaves the pad an undriven input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      out_q <= out_d;
      oe_q  <= oe_d;
    end
  end

  assign pin_out = out_q;
  assign pin_oe  = oe_q;

endmodule

// ### rtl/sspi_port.sv
`timescale 1ns/10ps
`include "sspi_params.svh"
module sspi_port
  import sspi_pkg::*;
#(
  parameter int WORD_W = `SSPI_WORD_W
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  input  wire logic [5:0]  port_d_in,
  output logic      [5:0]  port_d_out,
  output logic      [5:0]  port_d_oe
);

  localparam int CNT_W = $clog2(WORD_W + 1);

  if (WORD_W < 2 || WORD_W > 32) begin : g_chk
    $error("sspi_port: WORD_W must lie in 2..32");
  end

  // apb and register state
  logic              pready_q, pready_d;
  logic              pslverr_q, pslverr_d;
  logic [31:0]       prdata_q, prdata_d;
  logic [5:0]        pd_ctrl_q, pd_ctrl_d;
  logic [5:0]        pd_dir_q, pd_dir_d;
  logic [5:0]        pd_data_q, pd_data_d;
  sspi_cfg_t         cfg_q, cfg_d;
  logic [WORD_W-1:0] tx_buf_q, tx_buf_d;
  logic              acc, hit, wr, rd_rx, wr_tx, clr_ovr;
  // serial engine state
  logic [7:0]        div_cnt_q, div_cnt_d;
  logic              clk_int_q, clk_int_d;
  logic [CNT_W-1:0]  int_bit_q, int_bit_d;
  logic              fs_int_q, fs_int_d;
  sspi_shift_t       tx_st_q, tx_st_d;
  logic [WORD_W-1:0] tx_sh_q, tx_sh_d;
  logic [CNT_W-1:0]  tx_cnt_q, tx_cnt_d;
  logic              tx_bit_q, tx_bit_d;
  logic              tx_full_q, tx_full_d;
  sspi_shift_t       rx_st_q, rx_st_d;
  logic [WORD_W-1:0] rx_sh_q, rx_sh_d;
  logic [CNT_W-1:0]  rx_cnt_q, rx_cnt_d;
  logic [WORD_W-1:0] rx_buf_q, rx_buf_d;
  logic              rx_full_q, rx_full_d;
  logic              rx_ovr_q, rx_ovr_d;
  logic              tx_clk_prev_q, rx_clk_prev_q;
  logic              tx_clk_lvl, tx_fs_lvl, rx_clk_lvl, rx_fs_lvl;
  logic              tx_rise, rx_fall, tx_load, rx_done, run;
  logic [5:0]        pin_s;
  sspi_pinfn_t       fn;

  // wait_mode is deliberately unused: waiting changes nothing here
  assign run = ce && !stop_mode;

  // pads are async to pclk; stop freezes the samples so inputs are ignored
  sspi_sync #(
    .W (`SSPI_NPINS)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (run),
    .d       (port_d_in),
    .q       (pin_s)
  );

  // apb: one wait state, so pready is a registered single-cycle pulse
  assign acc     = psel && penable;
  assign wr      = acc && pready_q && pwrite;
  assign rd_rx   = acc && pready_q && !pwrite && paddr == `SSPI_OFF_RX;
  assign wr_tx   = wr && paddr == `SSPI_OFF_TX;
  assign clr_ovr = wr && paddr == `SSPI_OFF_STAT && pwdata[`SSPI_ST_RX_OVR];

  always_comb begin
    hit       = 1'b1;
    prdata_d  = prdata_q;
    pd_ctrl_d = pd_ctrl_q;
    pd_dir_d  = pd_dir_q;
    pd_data_d = pd_data_q;
    cfg_d     = cfg_q;
    tx_buf_d  = tx_buf_q;
    case (paddr)
      `SSPI_OFF_PD_CTRL: prdata_d = 32'(pd_ctrl_q);
      `SSPI_OFF_PD_DIR:  prdata_d = 32'(pd_dir_q);
      `SSPI_OFF_PD_DATA: prdata_d = 32'(pin_s);
      `SSPI_OFF_CFG:     prdata_d = 32'(cfg_q);
      `SSPI_OFF_TX:      prdata_d = 32'(tx_buf_q);
      `SSPI_OFF_RX:      prdata_d = 32'(rx_buf_q);
      `SSPI_OFF_STAT:    prdata_d = 32'({pin_s[`SSPI_PIN_SC1], pin_s[`SSPI_PIN_SC0],
                                         rx_st_q == st_shift, tx_st_q == st_shift,
                                         rx_ovr_q, rx_full_q, tx_full_q});
      default: begin
        hit      = 1'b0;
        prdata_d = '0;
      end
    endcase
    if (!(acc && !pready_q)) begin
      prdata_d = prdata_q;                    // read data only moves when answered
    end
    pready_d  = acc && !pready_q;
    pslverr_d = acc && !pready_q && !hit;
    if (wr) begin
      case (paddr)
        `SSPI_OFF_PD_CTRL: pd_ctrl_d = pwdata[5:0];
        `SSPI_OFF_PD_DIR:  pd_dir_d  = pwdata[5:0];
        `SSPI_OFF_PD_DATA: pd_data_d = pwdata[5:0];
        `SSPI_OFF_CFG:     cfg_d     = sspi_cfg_t'(pwdata[`SSPI_CFG_W-1:0]);
        `SSPI_OFF_TX:      tx_buf_d  = pwdata[WORD_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
      pd_ctrl_q <= `SSPI_PINS_RST;
      pd_dir_q  <= `SSPI_PINS_RST;
      pd_data_q <= `SSPI_PINS_RST;
      cfg_q     <= `SSPI_CFG_RST;
      tx_buf_q  <= '0;
    end else if (ce) begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
      pd_ctrl_q <= pd_ctrl_d;
      pd_dir_q  <= pd_dir_d;
      pd_data_q <= pd_data_d;
      cfg_q     <= cfg_d;
      tx_buf_q  <= tx_buf_d;
    end
  end

  // clock and sync sources; edges are found on synchronised levels only,
  // which is safe for pad clocks whose halves last three or more pclk samples; an internal half lasts div plus one
  always_comb begin
    tx_clk_lvl = cfg_q.sck_out ? clk_int_q : pin_s[`SSPI_PIN_SCK];
    tx_fs_lvl  = cfg_q.fs_out ? fs_int_q : pin_s[`SSPI_PIN_SC2];
    rx_clk_lvl = tx_clk_lvl;
    rx_fs_lvl  = tx_fs_lvl;
    if (cfg_q.async_mode) begin
      rx_clk_lvl = cfg_q.sc0_out ? clk_int_q : pin_s[`SSPI_PIN_SC0];
      rx_fs_lvl  = cfg_q.sc1_out ? fs_int_q : pin_s[`SSPI_PIN_SC1];
    end
    tx_rise = tx_clk_lvl && !tx_clk_prev_q;
    rx_fall = !rx_clk_lvl && rx_clk_prev_q;
  end

  // serial engine: divider, frame generator, transmit and receive shifters
  always_comb begin
    div_cnt_d = '0;
    clk_int_d = 1'b0;
    int_bit_d = int_bit_q;
    fs_int_d  = fs_int_q;
    tx_st_d   = tx_st_q;
    tx_sh_d   = tx_sh_q;
    tx_cnt_d  = tx_cnt_q;
    tx_bit_d  = tx_bit_q;
    rx_st_d   = rx_st_q;
    rx_sh_d   = rx_sh_q;
    rx_cnt_d  = rx_cnt_q;
    rx_buf_d  = rx_buf_q;
    rx_done   = 1'b0;
    if (cfg_q.enable) begin
      div_cnt_d = div_cnt_q + 8'h01;
      clk_int_d = clk_int_q;
      if (div_cnt_q >= cfg_q.div) begin
        div_cnt_d = '0;
        clk_int_d = !clk_int_q;
        if (!clk_int_q) begin
          // a new bit starts on each internal rising edge
          int_bit_d = (int_bit_q == CNT_W'(WORD_W - 1)) ? '0 : int_bit_q + 1'b1;
          fs_int_d  = (int_bit_d == '0);
        end
      end
    end
    // reload at the word end lets frames run back to back
    tx_load = cfg_q.enable && tx_rise && tx_fs_lvl && tx_full_q
              && (tx_st_q == st_idle || tx_cnt_q == CNT_W'(WORD_W));
    unique case (tx_st_q)
      st_idle: ;
      st_shift: begin
        if (tx_rise) begin
          if (tx_cnt_q == CNT_W'(WORD_W)) begin
            tx_st_d = st_idle;
          end else begin
            tx_bit_d = tx_sh_q[WORD_W-1];
            tx_sh_d  = tx_sh_q << 1;
            tx_cnt_d = tx_cnt_q + 1'b1;
          end
        end
      end
    endcase
    if (tx_load) begin
      tx_st_d  = st_shift;
      tx_bit_d = tx_buf_q[WORD_W-1];
      tx_sh_d  = tx_buf_q << 1;
      tx_cnt_d = CNT_W'(1);
    end
    // receive samples on the falling edge, half a bit after launch
    unique case (rx_st_q)
      st_idle: begin
        if (rx_fall && rx_fs_lvl && cfg_q.enable) begin
          rx_sh_d  = {rx_sh_q[WORD_W-2:0], pin_s[`SSPI_PIN_SRD]};
          rx_cnt_d = CNT_W'(1);
          rx_st_d  = st_shift;
        end
      end
      st_shift: begin
        if (rx_fall) begin
          rx_sh_d  = {rx_sh_q[WORD_W-2:0], pin_s[`SSPI_PIN_SRD]};
          rx_cnt_d = rx_cnt_q + 1'b1;
          if (rx_cnt_d == CNT_W'(WORD_W)) begin
            rx_buf_d = rx_sh_d;
            rx_done  = 1'b1;
            rx_st_d  = st_idle;
          end
        end
      end
    endcase
    // disabling the port abandons any half-shifted word, so a later frame starts clean
    if (!cfg_q.enable) begin
      tx_st_d = st_idle;
      rx_st_d = st_idle;
    end
    // flag updates: the setting event wins over a same-cycle clear, so a tx write beats the load that empties the buffer
    tx_full_d = wr_tx ? 1'b1 : (tx_load ? 1'b0 : tx_full_q);
    rx_full_d = rx_done ? 1'b1 : (rd_rx ? 1'b0 : rx_full_q);
    rx_ovr_d  = (rx_done && rx_full_q && !rd_rx) ? 1'b1 : (clr_ovr ? 1'b0 : rx_ovr_q);
  end

  // stop freezes the engine so it resumes where it left off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q     <= '0;
      clk_int_q     <= 1'b0;
      int_bit_q     <= '0;
      fs_int_q      <= 1'b0;
      tx_st_q       <= st_idle;
      tx_sh_q       <= '0;
      tx_cnt_q      <= '0;
      tx_bit_q      <= 1'b0;
      tx_full_q     <= 1'b0;
      rx_st_q       <= st_idle;
      rx_sh_q       <= '0;
      rx_cnt_q      <= '0;
      rx_buf_q      <= '0;
      rx_full_q     <= 1'b0;
      rx_ovr_q      <= 1'b0;
      tx_clk_prev_q <= 1'b0;
      rx_clk_prev_q <= 1'b0;
    end else if (run) begin
      div_cnt_q     <= div_cnt_d;
      clk_int_q     <= clk_int_d;
      int_bit_q     <= int_bit_d;
      fs_int_q      <= fs_int_d;
      tx_st_q       <= tx_st_d;
      tx_sh_q       <= tx_sh_d;
      tx_cnt_q      <= tx_cnt_d;
      tx_bit_q      <= tx_bit_d;
      tx_full_q     <= tx_full_d;
      rx_st_q       <= rx_st_d;
      rx_sh_q       <= rx_sh_d;
      rx_cnt_q      <= rx_cnt_d;
      rx_buf_q      <= rx_buf_d;
      rx_full_q     <= rx_full_d;
      rx_ovr_q      <= rx_ovr_d;
      tx_clk_prev_q <= tx_clk_lvl;
      rx_clk_prev_q <= rx_clk_lvl;
    end
  end

  // serial drive per pin; in sync mode lines zero and one carry the flags
  always_comb begin
    fn.oe  = {tx_st_q == st_shift, 1'b0, cfg_q.sck_out, cfg_q.fs_out,
              cfg_q.sc1_out, cfg_q.sc0_out};
    fn.out = {tx_bit_q, 1'b0, clk_int_q, fs_int_q,
              cfg_q.async_mode ? fs_int_q : cfg_q.flag1,
              cfg_q.async_mode ? clk_int_q : cfg_q.flag0};
  end

  for (genvar i = 0; i < `SSPI_NPINS; i++) begin : g_pin
    sspi_pin_cell u_cell (
      .pclk     (pclk),
      .presetn  (presetn),
      .ce       (ce),
      .stop     (stop_mode),
      .func_sel (pd_ctrl_q[i]),
      .gpio_dir (pd_dir_q[i]),
      .gpio_out (pd_data_q[i]),
      .fn_oe    (fn.oe[i]),
      .fn_out   (fn.out[i]),
      .pin_out  (port_d_out[i]),
      .pin_oe   (port_d_oe[i])
    );
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // checks
  logic seen_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_reset_gpio;
    !seen_q |-> pd_ctrl_q == '0 && port_d_oe == '0;
  endproperty
  a_reset_gpio: assert property (p_reset_gpio) else $error("pins not gpio inputs");

  property p_gpio_dir;
    run && !pd_ctrl_q[`SSPI_PIN_SC2]
      |=> port_d_oe[`SSPI_PIN_SC2] == $past(pd_dir_q[`SSPI_PIN_SC2]);
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) else $error("gpio direction wrong");

  property p_stop_float;
    ce && stop_mode |=> port_d_oe == '0;
  endproperty
  a_stop_float: assert property (p_stop_float) else $error("output driven in stop");

  property p_rx_input;
    run && pd_ctrl_q[`SSPI_PIN_SRD] |=> !port_d_oe[`SSPI_PIN_SRD];
  endproperty
  a_rx_input: assert property (p_rx_input) else $error("receive pin driven");

  property p_tx_drive;
    run && pd_ctrl_q[`SSPI_PIN_STD] && tx_st_q == st_shift
      |=> port_d_oe[`SSPI_PIN_STD] && port_d_out[`SSPI_PIN_STD] == $past(tx_bit_q);
  endproperty
  a_tx_drive: assert property (p_tx_drive) else $error("transmit pin not driven");

  property p_sck_out;
    run && pd_ctrl_q[`SSPI_PIN_SCK] && cfg_q.sck_out
      |=> port_d_oe[`SSPI_PIN_SCK] && port_d_out[`SSPI_PIN_SCK] == $past(clk_int_q);
  endproperty
  a_sck_out: assert property (p_sck_out) else $error("bit clock not driven");

  property p_fs_out;
    run && pd_ctrl_q[`SSPI_PIN_SC2] && cfg_q.fs_out
      |=> port_d_out[`SSPI_PIN_SC2] == $past(fs_int_q);
  endproperty
  a_fs_out: assert property (p_fs_out) else $error("frame sync not driven");

  property p_sc0_flag;
    run && pd_ctrl_q[`SSPI_PIN_SC0] && cfg_q.sc0_out && !cfg_q.async_mode
      |=> port_d_out[`SSPI_PIN_SC0] == $past(cfg_q.flag0);
  endproperty
  a_sc0_flag: assert property (p_sc0_flag) else $error("flag zero wrong");

  property p_sc0_clk;
    run && pd_ctrl_q[`SSPI_PIN_SC0] && cfg_q.sc0_out && cfg_q.async_mode
      |=> port_d_out[`SSPI_PIN_SC0] == $past(clk_int_q);
  endproperty
  a_sc0_clk: assert property (p_sc0_clk) else $error("rx clock wrong");

  property p_apb_wait;
    ce && psel && penable && !pready_q |=> pready_q ##1 (!pready_q || !$past(ce));
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer timing wrong");

  c_tx_word: cover property (tx_st_q == st_shift ##1 tx_st_q == st_idle);
  c_rx_word: cover property (rx_done && run);
  c_rx_ovr:  cover property (run && rx_done && rx_full_q);
  c_stop:    cover property ($rose(stop_mode) && |pd_ctrl_q);

endmodule

// ### test/sspi_codec_model.sv
`timescale 1ns/10ps
// far-side codec: supplies bit clock, frame sync and receive data, samples transmit data
module sspi_codec_model #(
  parameter int WORD_W = 8
) (
  input  wire logic              start,
  input  wire logic [WORD_W-1:0] word_out,
  input  wire logic [5:0]        ext_lvl,
  input  wire logic [5:0]        pad_out,
  input  wire logic [5:0]        pad_oe,
  output logic      [5:0]        pad_in,
  output logic      [WORD_W-1:0] word_in,
  output logic                   done
);
  logic       clk;
  logic       fs;
  logic       rxd;
  logic [5:0] drv;

  initial begin
    clk = 1'b0;
    fs = 1'b0;
    rxd = 1'b0;
    done = 1'b0;
    word_in = '0;
  end

  // pad level: the device wins where it drives, else the far side
  assign drv = {ext_lvl[5], rxd, clk, fs, ext_lvl[1:0]};
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & drv);

  // one frame; the clock stands still low outside frames
  always @(posedge start) begin
    #10; // keep pad changes clear of the device's sampling edges
    for (int i = 0; i < WORD_W; i++) begin
      #50;
      if (i > 0) begin
        word_in = {word_in[WORD_W-2:0], pad_in[5]};
      end
      fs = (i == 0);
      rxd = word_out[WORD_W-1-i];
      #50 clk = 1'b1;
      #100 clk = 1'b0; // halves of 4 system clocks
    end
    #50 word_in = {word_in[WORD_W-2:0], pad_in[5]};
    fs = 1'b0;
    rxd = ~rxd; // released data line must not look held
    done = ~done;
  end
endmodule

// ### test/sspi_port_tb.sv
`timescale 1ns/10ps
`include "sspi_params.svh"
`define CHK(got, exp) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("Error at %0t ns: got %h expected %h", $time, got, exp); \
  end \
end
module sspi_port_tb;
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wait_mode;
  logic        stop_mode;
  logic        start;
  logic        done;
  logic        std_seen;
  logic [5:0]  port_d_in;
  logic [5:0]  port_d_out;
  logic [5:0]  port_d_oe;
  logic [5:0]  ext_lvl;
  logic [7:0]  word_out;
  logic [7:0]  word_in;
  logic [31:0] r;
  int          miscompares;
  int          n_tests;

  sspi_port #(.WORD_W(8)) i_sspi_port (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .port_d_in(port_d_in), .port_d_out(port_d_out),
    .port_d_oe(port_d_oe)
  );

  sspi_codec_model #(.WORD_W(8)) i_sspi_codec_model (
    .start(start), .word_out(word_out), .ext_lvl(ext_lvl), .pad_out(port_d_out),
    .pad_oe(port_d_oe), .pad_in(port_d_in), .word_in(word_in), .done(done)
  );

  // 40 mhz system clock
  always #12.5 pclk = ~pclk;

  // remember whether the transmit pad was driven while a frame ran
  always @(posedge pclk) begin
    if (start === 1'b1 && port_d_oe[5] === 1'b1) begin
      std_seen <= 1'b1;
    end
  end

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge pclk);
  endtask

  // one apb transfer; the request holds until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rdat, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      $display("Error at %0t ns: no apb answer", $time);
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        e;
    apb(1'b1, a, d, x, e);
  endtask

  task automatic rd(input logic [7:0] a);
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
  endtask

  // count toggles of one pad and whether another pad went high, over 40 cycles
  task automatic watch(input int ck, input int sy, output int tg, output logic hi);
    logic prev;
    tg = 0;
    hi = 1'b0;
    prev = port_d_out[ck];
    repeat (40) begin
      settle(1);
      if (port_d_out[ck] !== prev) begin
        tg++;
      end
      prev = port_d_out[ck];
      hi = hi | (port_d_out[sy] === 1'b1);
    end
  endtask

  task automatic t_reset;
    logic e;
    `CHK(port_d_oe, 6'h00)
    rd(`SSPI_OFF_PD_CTRL);
    `CHK(r, 32'h0000_0000)
    rd(`SSPI_OFF_CFG);
    `CHK(r[15:0], `SSPI_CFG_RST)
    apb(1'b0, 8'h1C, 32'h0000_0000, r, e);
    `CHK(e, 1'b1)
  endtask

  task automatic t_gpio;
    wr(`SSPI_OFF_PD_DIR, 32'h0000_003F);
    wr(`SSPI_OFF_PD_DATA, 32'h0000_002A);
    settle(2);
    `CHK(port_d_oe, 6'h3F)
    `CHK(port_d_out, 6'h2A)
    @(posedge pclk) wait_mode <= 1'b1;
    settle(8);
    `CHK({port_d_oe, port_d_out}, 12'hFEA)
    @(posedge pclk) stop_mode <= 1'b1;
    settle(3);
    `CHK(port_d_oe, 6'h00)
    `CHK(port_d_out, 6'h2A)
    @(posedge pclk) stop_mode <= 1'b0;
    wait_mode <= 1'b0;
    settle(3);
    `CHK(port_d_oe, 6'h3F)
    wr(`SSPI_OFF_PD_DIR, 32'h0000_0000);
    ext_lvl <= 6'h23;
    settle(4);
    rd(`SSPI_OFF_PD_DATA);
    `CHK(r[5:0], 6'h23)
    `CHK(port_d_oe, 6'h00)
  endtask

  task automatic t_serial;
    int   tg;
    logic hi;
    wr(`SSPI_OFF_PD_CTRL, 32'h0000_003F);
    wr(`SSPI_OFF_CFG, 32'h0000_0038);
    settle(2);
    `CHK(port_d_oe[1:0], 2'b11)
    `CHK(port_d_out[1:0], 2'b01)
    wr(`SSPI_OFF_CFG, 32'h0000_0058);
    settle(2);
    `CHK(port_d_out[1:0], 2'b10)
    wr(`SSPI_OFF_CFG, 32'h0000_0186);
    settle(2);
    `CHK({port_d_oe[4:2]}, 3'b011)
    watch(3, 2, tg, hi);
    `CHK(tg inside {[19:21]}, 1'b1)
    `CHK(hi, 1'b1)
    // clock enable low must freeze the running bit clock pad
    @(posedge pclk) ce <= 1'b0;
    settle(1);
    watch(3, 2, tg, hi);
    `CHK(tg, 0)
    @(posedge pclk) ce <= 1'b1;
    wr(`SSPI_OFF_CFG, 32'h0000_0199);
    settle(2);
    watch(0, 1, tg, hi);
    `CHK(tg inside {[19:21]}, 1'b1)
    `CHK(hi, 1'b1)
  endtask

  task automatic t_frame;
    int   n;
    logic prev;
    n = 0;
    // disabling first drops any half-shifted word left by the last test
    wr(`SSPI_OFF_CFG, 32'h0000_0000);
    rd(`SSPI_OFF_RX);
    wr(`SSPI_OFF_STAT, 32'h0000_0004);
    wr(`SSPI_OFF_CFG, 32'h0000_0080);
    wr(`SSPI_OFF_TX, 32'h0000_00A5);
    `CHK(port_d_oe[5], 1'b0)
    prev = done;
    @(posedge pclk);
    word_out <= 8'h3C;
    start <= 1'b1;
    while (done === prev && n < 2000) begin
      settle(1);
      n++;
    end
    `CHK(n < 2000, 1'b1)
    @(posedge pclk) start <= 1'b0;
    settle(6);
    `CHK(word_in, 8'hA5)
    `CHK(std_seen, 1'b1)
    rd(`SSPI_OFF_STAT);
    `CHK(r[1], 1'b1)
    `CHK(r[2], 1'b0)
    rd(`SSPI_OFF_RX);
    `CHK(r[7:0], 8'h3C)
    `CHK(port_d_oe[4], 1'b0)
  endtask

  // watchdog, far beyond the few hundred cycles the tests take
  initial begin
    #2000000;
    miscompares++;
    $display("Error at %0t ns: watchdog expired", $time);
    report_and_stop;
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, wait_mode, stop_mode, start, std_seen} = '0;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ext_lvl = 6'h00;
    word_out = 8'h00;
    miscompares = 0;
    n_tests = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_gpio;
    t_serial;
    t_frame;
    report_and_stop;
  end
endmodule
